// ---- dtt_pkg.sv ----
package dtt_pkg;

    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [15:0] ADDR_PORT0_FUNCTION_CONTROL = 16'hfe42;
    localparam logic [15:0] ADDR_TIMER_PAIR_CONTROL = 16'hfe78;
    localparam logic [15:0] ADDR_FIRST_TIMER_PERIOD = 16'hfe7a;
    localparam logic [15:0] ADDR_SECOND_TIMER_PERIOD = 16'hfe7b;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_PORT0_FUNCTION_CONTROL = 8'h00;
    localparam logic [7:0] RST_TIMER_PAIR_CONTROL = 8'h00;
    localparam logic [7:0] RST_TIMER_PERIOD = 8'h00;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [5:0] RST_PRESCALER = 6'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;

    // ----------------------------------------
    // timer_pair_control field positions
    // ----------------------------------------
    localparam int FIRST_IRQ_ENABLE_BIT = 0;
    localparam int FIRST_OVERFLOW_FLAG_BIT = 1;
    localparam int SECOND_IRQ_ENABLE_BIT = 2;
    localparam int SECOND_OVERFLOW_FLAG_BIT = 3;
    localparam int FIRST_CLOCK_SELECT_LO_BIT = 4;
    localparam int SECOND_CLOCK_SELECT_LO_BIT = 6;

    // ----------------------------------------
    // port0_function_control field positions
    // ----------------------------------------
    localparam int FIRST_TOGGLE_OUT_ENABLE_BIT = 6;
    localparam int SECOND_TOGGLE_OUT_ENABLE_BIT = 7;

    // ----------------------------------------
    // clock select codes and prescale masks
    // ----------------------------------------
    localparam logic [1:0] SEL_STOP = 2'h0;
    localparam logic [1:0] SEL_DIV4 = 2'h1;
    localparam logic [1:0] SEL_DIV16 = 2'h2;
    localparam logic [1:0] SEL_DIV64 = 2'h3;
    localparam logic [5:0] MASK_DIV4 = 6'h03;
    localparam logic [5:0] MASK_DIV16 = 6'h0f;
    localparam logic [5:0] MASK_DIV64 = 6'h3f;

endpackage

// ---- dtt_timer_pair.sv ----
// Strobed register access was decided locally.
module dtt_timer_pair
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // interrupt
    output logic timer_irq,
    // port 0 pin 6 and pin 7 data latch and direction
    input wire logic port0_pin6_latch,
    input wire logic port0_pin7_latch,
    input wire logic port0_pin6_output_mode,
    input wire logic port0_pin7_output_mode,
    // port 0 pin 6 and pin 7 drive
    output logic port0_pin6_out,
    output logic port0_pin6_oe,
    output logic port0_pin7_out,
    output logic port0_pin7_oe
);

    // ----------------------------------------
    // registers and decode
    // ----------------------------------------
    logic [7:0] timer_pair_control_reg;
    logic [7:0] port0_function_control_reg;
    logic [7:0] first_timer_period_reg;
    logic [7:0] second_timer_period_reg;
    logic [7:0] reg_rdata_reg;
    logic wr_control;
    logic wr_port_function;
    logic [1:0] wr_period;
    logic [1:0] clock_select [2];
    logic [7:0] period [2];
    logic [5:0] prescaler_reg [2];
    logic [7:0] count_reg [2];
    logic [1:0] tick;
    logic [1:0] wrap;
    logic [1:0] running;
    logic [1:0] overflow_flag_reg;
    logic [1:0] irq_enable;
    logic [1:0] wave_reg;
    logic [1:0] toggle_out_enable;
    logic [1:0] pin_latch;
    logic [1:0] pin_output_mode;
    logic [1:0] pin_out_reg;
    logic [1:0] overflow_clear;

    assign wr_control = reg_write && (reg_addr == dtt_pkg::ADDR_TIMER_PAIR_CONTROL);
    assign wr_port_function = reg_write && (reg_addr == dtt_pkg::ADDR_PORT0_FUNCTION_CONTROL);
    assign wr_period[0] = reg_write && (reg_addr == dtt_pkg::ADDR_FIRST_TIMER_PERIOD);
    assign wr_period[1] = reg_write && (reg_addr == dtt_pkg::ADDR_SECOND_TIMER_PERIOD);

    // first timer select at 5:4, second at 7:6
    assign clock_select[0] = timer_pair_control_reg[dtt_pkg::FIRST_CLOCK_SELECT_LO_BIT +: 2];
    assign clock_select[1] = timer_pair_control_reg[dtt_pkg::SECOND_CLOCK_SELECT_LO_BIT +: 2];
    assign period[0] = first_timer_period_reg;
    assign period[1] = second_timer_period_reg;
    assign irq_enable[0] = timer_pair_control_reg[dtt_pkg::FIRST_IRQ_ENABLE_BIT];
    assign irq_enable[1] = timer_pair_control_reg[dtt_pkg::SECOND_IRQ_ENABLE_BIT];
    assign toggle_out_enable[0] = port0_function_control_reg[dtt_pkg::FIRST_TOGGLE_OUT_ENABLE_BIT];
    assign toggle_out_enable[1] = port0_function_control_reg[dtt_pkg::SECOND_TOGGLE_OUT_ENABLE_BIT];
    assign pin_latch = {port0_pin7_latch, port0_pin6_latch};
    assign pin_output_mode = {port0_pin7_output_mode, port0_pin6_output_mode};

    // write-one-to-clear on the overflow bits of the control register
    assign overflow_clear[0] = wr_control && reg_wdata[dtt_pkg::FIRST_OVERFLOW_FLAG_BIT];
    assign overflow_clear[1] = wr_control && reg_wdata[dtt_pkg::SECOND_OVERFLOW_FLAG_BIT];

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            timer_pair_control_reg <= dtt_pkg::RST_TIMER_PAIR_CONTROL;
        end
        else
        begin
            if (wr_control)
            begin
                timer_pair_control_reg <= reg_wdata;
            end
            // flags are owned by the block, never by the plain store
            timer_pair_control_reg[dtt_pkg::FIRST_OVERFLOW_FLAG_BIT] <= overflow_flag_reg[0];
            timer_pair_control_reg[dtt_pkg::SECOND_OVERFLOW_FLAG_BIT] <= overflow_flag_reg[1];
        end
    end

    // ----------------------------------------
    // overflow flags
    // ----------------------------------------
    // set wins over a clear in the same cycle so no wrap is lost
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            overflow_flag_reg <= 2'h0;
        end
        else
        begin
            overflow_flag_reg <= wrap | (overflow_flag_reg & ~overflow_clear);
        end
    end

    // ----------------------------------------
    // period and port function registers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            first_timer_period_reg <= dtt_pkg::RST_TIMER_PERIOD;
            second_timer_period_reg <= dtt_pkg::RST_TIMER_PERIOD;
            port0_function_control_reg <= dtt_pkg::RST_PORT0_FUNCTION_CONTROL;
        end
        else
        begin
            if (wr_period[0])
            begin
                first_timer_period_reg <= reg_wdata;
            end
            if (wr_period[1])
            begin
                second_timer_period_reg <= reg_wdata;
            end
            if (wr_port_function)
            begin
                port0_function_control_reg <= reg_wdata;
            end
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    // unmapped addresses and idle cycles read zero
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            reg_rdata_reg <= dtt_pkg::RST_READ_DATA;
        end
        else if (reg_read)
        begin
            unique case (reg_addr)
                dtt_pkg::ADDR_TIMER_PAIR_CONTROL:
                    reg_rdata_reg <= timer_pair_control_reg;
                dtt_pkg::ADDR_PORT0_FUNCTION_CONTROL:
                    reg_rdata_reg <= port0_function_control_reg;
                dtt_pkg::ADDR_FIRST_TIMER_PERIOD:
                    reg_rdata_reg <= first_timer_period_reg;
                dtt_pkg::ADDR_SECOND_TIMER_PERIOD:
                    reg_rdata_reg <= second_timer_period_reg;
                default:
                    reg_rdata_reg <= dtt_pkg::RST_READ_DATA;
            endcase
        end
        else
        begin
            reg_rdata_reg <= dtt_pkg::RST_READ_DATA;
        end
    end

    assign reg_rdata = reg_rdata_reg;

    // ----------------------------------------
    // two prescaled interval timers
    // ----------------------------------------
    genvar t;
    generate
        for (t = 0; t < 2; t = t + 1)
        begin : g_timer
            logic [5:0] mask;

            // prescaler free-runs; low bits all ones mark the tick
            always_comb
            begin
                unique case (clock_select[t])
                    dtt_pkg::SEL_DIV4: mask = dtt_pkg::MASK_DIV4;
                    dtt_pkg::SEL_DIV16: mask = dtt_pkg::MASK_DIV16;
                    dtt_pkg::SEL_DIV64: mask = dtt_pkg::MASK_DIV64;
                    dtt_pkg::SEL_STOP: mask = dtt_pkg::MASK_DIV64;
                endcase
            end

            assign running[t] = (clock_select[t] != dtt_pkg::SEL_STOP);
            assign tick[t] = running[t] && !wr_period[t]
                && ((prescaler_reg[t] & mask) == mask);
            assign wrap[t] = tick[t] && (count_reg[t] == period[t]);

            // 6-bit prescaler per timer, cleared while stopped or on period write
            always_ff @(posedge clk_sys)
            begin
                if (reset || !running[t] || wr_period[t])
                begin
                    prescaler_reg[t] <= dtt_pkg::RST_PRESCALER;
                end
                else
                begin
                    prescaler_reg[t] <= prescaler_reg[t] + 6'h01;
                end
            end

            // 8-bit counter wraps on the tick after matching its period
            always_ff @(posedge clk_sys)
            begin
                if (reset || !running[t] || wr_period[t])
                begin
                    count_reg[t] <= dtt_pkg::RST_COUNT;
                end
                else if (wrap[t])
                begin
                    count_reg[t] <= dtt_pkg::RST_COUNT;
                end
                else if (tick[t])
                begin
                    count_reg[t] <= count_reg[t] + 8'h01;
                end
            end

            // toggle waveform, one level change per period
            always_ff @(posedge clk_sys)
            begin
                if (reset || !running[t])
                begin
                    wave_reg[t] <= 1'b0;
                end
                else if (wrap[t])
                begin
                    wave_reg[t] <= !wave_reg[t];
                end
            end

            // pin drive registered; direction comes straight from the port logic
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                begin
                    pin_out_reg[t] <= 1'b0;
                end
                else
                begin
                    pin_out_reg[t] <= pin_latch[t]
                        | (toggle_out_enable[t] && pin_output_mode[t] && wave_reg[t]);
                end
            end

            stopped_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
                !running[t] |=> (count_reg[t] == 8'h00) && (prescaler_reg[t] == 6'h00))
                else $error("stopped timer left nonzero count");

            tick_spacing_a: assert property (@(posedge clk_sys) disable iff (reset)
                tick[t] |=> !tick[t] [*3])
                else $error("prescaler ticks closer than four cycles");

            wrap_sets_a: assert property (@(posedge clk_sys) disable iff (reset)
                wrap[t] |=> (count_reg[t] == 8'h00) && overflow_flag_reg[t])
                else $error("wrap did not zero counter and set flag");

            count_step_a: assert property (@(posedge clk_sys) disable iff (reset)
                (tick[t] && !wrap[t]) |=> (count_reg[t] == $past(count_reg[t]) + 8'h01))
                else $error("counter did not advance on tick");

            period_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
                wr_period[t] |=> (count_reg[t] == 8'h00) && (prescaler_reg[t] == 6'h00)
                    && !tick[t])
                else $error("period write did not restart timer");

            flag_sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
                (overflow_flag_reg[t] && !overflow_clear[t]) |=> overflow_flag_reg[t])
                else $error("overflow flag dropped without software clear");

            wave_toggle_a: assert property (@(posedge clk_sys) disable iff (reset)
                wrap[t] |=> (wave_reg[t] != $past(wave_reg[t])))
                else $error("waveform did not invert on wrap");

            pin_drive_a: assert property (@(posedge clk_sys) disable iff (reset)
                ##1 pin_out_reg[t] == ($past(pin_latch[t]) | ($past(toggle_out_enable[t])
                    && $past(pin_output_mode[t]) && $past(wave_reg[t]))))
                else $error("pin drive differs from latch and waveform");

            // ----------------------------------------
            // prescaler, counter, flag, waveform, pin and interrupt checks
            // ----------------------------------------
            prescale_step_a: assert property (@(posedge clk_sys) disable iff (reset)
                (running[t] && !wr_period[t])
                    |=> (prescaler_reg[t] == $past(prescaler_reg[t]) + 6'h01))
                else $error("prescaler did not advance while running");

            tick_repeat_a: assert property (@(posedge clk_sys) disable iff (reset)
                (tick[t] && (clock_select[t] == dtt_pkg::SEL_DIV4))
                    ##1 (!wr_period[t] && (clock_select[t] == dtt_pkg::SEL_DIV4)) [*4]
                    |-> tick[t])
                else $error("fastest prescale tick not every fourth cycle");

            count_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
                ((count_reg[t] != 8'h00) && running[t] && !wr_period[t] && !wrap[t])
                    |=> (count_reg[t] != 8'h00))
                else $error("counter returned to zero without a wrap");

            flag_set_only_a: assert property (@(posedge clk_sys) disable iff (reset)
                (!overflow_flag_reg[t] && !wrap[t]) |=> !overflow_flag_reg[t])
                else $error("overflow flag set without a wrap");

            wave_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
                (running[t] && !wrap[t]) |=> (wave_reg[t] == $past(wave_reg[t])))
                else $error("waveform changed between wraps");

            input_pin_a: assert property (@(posedge clk_sys) disable iff (reset)
                !pin_output_mode[t] |=> (pin_out_reg[t] == $past(pin_latch[t])))
                else $error("toggle reached a pin set as input");

            // an enabled wrap must raise the request unless software rewrote the enables
            irq_on_wrap_a: assert property (@(posedge clk_sys) disable iff (reset)
                (wrap[t] && irq_enable[t] && !wr_control) |=> timer_irq)
                else $error("enabled wrap did not raise interrupt");
        end
    endgenerate

    // ----------------------------------------
    // interrupt and pins
    // ----------------------------------------
    assign timer_irq = |(irq_enable & overflow_flag_reg);
    assign port0_pin6_out = pin_out_reg[0];
    assign port0_pin7_out = pin_out_reg[1];
    // enable follows direction so an input pin is never driven
    assign port0_pin6_oe = port0_pin6_output_mode;
    assign port0_pin7_oe = port0_pin7_output_mode;

    irq_level_a: assert property (@(posedge clk_sys) disable iff (reset)
        (overflow_flag_reg[0] && irq_enable[0] && !overflow_clear[0]) |=> timer_irq
            || !irq_enable[0])
        else $error("interrupt not held while enabled flag set");

    flag_readback_a: assert property (@(posedge clk_sys) disable iff (reset)
        ##1 timer_pair_control_reg[dtt_pkg::SECOND_OVERFLOW_FLAG_BIT]
            == $past(overflow_flag_reg[1]))
        else $error("control register does not show second flag");

    // only a control write may drop the request: flags are sticky and enables stored
    irq_held_a: assert property (@(posedge clk_sys) disable iff (reset)
        (timer_irq && !wr_control) |=> timer_irq)
        else $error("interrupt dropped without a control write");

    oe_direction_a: assert property (@(posedge clk_sys) disable iff (reset)
        (port0_pin6_oe == port0_pin6_output_mode) && (port0_pin7_oe == port0_pin7_output_mode))
        else $error("pin enable differs from pin direction");

endmodule

// ---- dual_8bit_interval_timer_toggle_tb_top.sv ----
module dual_8bit_interval_timer_toggle_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys;
    logic reset;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_rdata;
    logic timer_irq;
    logic [1:0] pin_latch;
    logic [1:0] pin_mode;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    int fail_count;
    int compares;
    integer seed;

    dtt_timer_pair u_dtt_timer_pair
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .timer_irq(timer_irq),
        .port0_pin6_latch(pin_latch[0]),
        .port0_pin7_latch(pin_latch[1]),
        .port0_pin6_output_mode(pin_mode[0]),
        .port0_pin7_output_mode(pin_mode[1]),
        .port0_pin6_out(pin_out[0]),
        .port0_pin6_oe(pin_oe[0]),
        .port0_pin7_out(pin_out[1]),
        .port0_pin7_oe(pin_oe[1])
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // bench helpers
    // ----------------------------------------
    task automatic give_verdict();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR time %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // a bounded wait: a lost toggle shows up as a wrong count
    task automatic wait_toggle(input int t, output int n);
        logic last;
        #1 last = pin_out[t];
        n = 0;
        repeat (2000)
        begin
            @(posedge clk_sys);
            #1 n++;
            if (pin_out[t] !== last)
                break;
        end
    endtask

    function automatic int period_cycles(input int p, input int sel);
        return (p + 1) * (4 ** sel);
    endfunction

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        fail_count++;
        $display("ERROR time %0t got %h expected %h", $time, 1'b0, 1'b1);
        give_verdict();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [15:0] addrs [5];
        logic [15:0] per_addr [2];
        logic [7:0] rd;
        logic [7:0] d;
        logic [7:0] ctrl;
        logic [7:0] flag;
        logic [1:0] en;
        logic stuck;
        int n;
        int p;
        int tog;
        seed = 32'h167f;
        fail_count = 0;
        compares = 0;
        reset = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        pin_latch = 2'b00;
        pin_mode = 2'b11;
        addrs = '{dtt_pkg::ADDR_PORT0_FUNCTION_CONTROL, dtt_pkg::ADDR_TIMER_PAIR_CONTROL,
            dtt_pkg::ADDR_FIRST_TIMER_PERIOD, dtt_pkg::ADDR_SECOND_TIMER_PERIOD, 16'hfe79};
        per_addr = '{dtt_pkg::ADDR_FIRST_TIMER_PERIOD, dtt_pkg::ADDR_SECOND_TIMER_PERIOD};
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;

        foreach (addrs[i])
        begin
            reg_rd(addrs[i], rd);
            chk(rd, 8'h00);
        end
        chk({pin_out, timer_irq}, 3'h0);
        $display("test reset_values done");

        repeat (8)
        begin
            d = $random(seed);
            reg_wr(dtt_pkg::ADDR_PORT0_FUNCTION_CONTROL, d);
            reg_rd(dtt_pkg::ADDR_PORT0_FUNCTION_CONTROL, rd);
            chk(rd, d);
            foreach (per_addr[i])
            begin
                d = $random(seed);
                reg_wr(per_addr[i], d);
                reg_rd(per_addr[i], rd);
                chk(rd, d);
            end
            d = $random(seed);
            reg_wr(dtt_pkg::ADDR_TIMER_PAIR_CONTROL, d & 8'h0f);
            reg_rd(dtt_pkg::ADDR_TIMER_PAIR_CONTROL, rd);
            chk(rd, d & 8'h05);
            reg_wr(16'hfe79, d);
            reg_rd(16'hfe79, rd);
            chk(rd, 8'h00);
        end
        reg_wr(dtt_pkg::ADDR_TIMER_PAIR_CONTROL, 8'h00);
        $display("test register_access done");

        // stopping between select codes so each run starts from zero
        reg_wr(dtt_pkg::ADDR_PORT0_FUNCTION_CONTROL, 8'hc0);
        for (int t = 0; t < 2; t++)
        begin
            for (int sel = 1; sel < 4; sel++)
            begin
                p = $random(seed) & 3;
                en[0] = (sel != 2);
                flag = 8'h02 << (2 * t);
                ctrl = (8'(sel) << (4 + 2 * t)) | (8'(en[0]) << (2 * t));
                reg_wr(per_addr[t], 8'(p));
                reg_wr(dtt_pkg::ADDR_TIMER_PAIR_CONTROL, ctrl);
                wait_toggle(t, n);
                // first wrap lands a full period after start, the pin register adds one
                chk(16'(n), 16'(period_cycles(p, sel) + 1));
                wait_toggle(t, n);
                chk(16'(n), 16'(period_cycles(p, sel)));
                chk(timer_irq, en[0]);
                reg_rd(dtt_pkg::ADDR_TIMER_PAIR_CONTROL, rd);
                chk(rd, ctrl | flag);
                p = $random(seed) & 3;
                repeat (2) @(posedge clk_sys);
                reg_wr(per_addr[t], 8'(p));
                wait_toggle(t, n);
                chk(16'(n), 16'(period_cycles(p, sel) + 1));
                reg_wr(dtt_pkg::ADDR_TIMER_PAIR_CONTROL, flag | (8'(en[0]) << (2 * t)));
                repeat (3) @(posedge clk_sys);
                stuck = 1'b0;
                repeat (70)
                begin
                    @(posedge clk_sys);
                    #1 stuck = stuck | pin_out[t];
                end
                chk(stuck, 1'b0);
                chk(timer_irq, 1'b0);
                reg_rd(dtt_pkg::ADDR_TIMER_PAIR_CONTROL, rd);
                chk(rd, 8'(en[0]) << (2 * t));
            end
        end
        $display("test timer_periods done");

        reg_wr(dtt_pkg::ADDR_FIRST_TIMER_PERIOD, 8'h00);
        reg_wr(dtt_pkg::ADDR_SECOND_TIMER_PERIOD, 8'h00);
        reg_wr(dtt_pkg::ADDR_TIMER_PAIR_CONTROL, 8'h55);
        repeat (24)
        begin
            d = $random(seed);
            en = {d[7], d[6]};
            reg_wr(dtt_pkg::ADDR_PORT0_FUNCTION_CONTROL, {d[7:6], 6'h00});
            pin_latch <= d[1:0];
            pin_mode <= d[3:2];
            repeat (3) @(posedge clk_sys);
            for (int t = 0; t < 2; t++)
            begin
                tog = 0;
                #1 stuck = pin_out[t];
                repeat (8)
                begin
                    @(posedge clk_sys);
                    #1 chk(pin_oe, pin_mode);
                    if (pin_out[t] !== stuck)
                        tog++;
                    stuck = pin_out[t];
                    if (pin_latch[t] || !pin_mode[t] || !en[t])
                        chk(pin_out[t], pin_latch[t]);
                end
                if (!pin_latch[t] && pin_mode[t] && en[t])
                    chk(16'(tog), 16'h0002);
            end
        end
        $display("test pin_mux done");
        give_verdict();
    end
endmodule
